// *** apv_pkg.sv ***
// constants for the auxiliary port, oscillator and divider register bank
package apv_pkg;
   localparam int          ADDR_W           = 5;
   localparam int          DATA_W           = 24;
   localparam logic [4:0]  ADDR_AUX_CTRL    = 5'h14;
   localparam logic [4:0]  ADDR_MAN_OSC     = 5'h15;
   localparam logic [4:0]  ADDR_GAIN_DIV    = 5'h16;
   localparam logic [23:0] RST_AUX_CTRL     = 24'h000220;
   localparam logic [23:0] RST_MAN_OSC      = 24'h0F48A0;
   localparam logic [23:0] RST_GAIN_DIV     = 24'h0006C1;
   // auxiliary_port_control fields
   localparam int          AUX_MODE_BIT     = 0;
   localparam int          AUX_VAL_LSB      = 1;
   localparam int          AUX_LVL_BIT      = 4;
   localparam int          AUX_PSYNC_BIT    = 9;
   localparam int          AUX_ROUTE_LSB    = 10;
   localparam int          AUX_OST_LSB      = 12;
   // manual_oscillator_config fields
   localparam int          OSC_MCAL_BIT     = 0;
   localparam int          OSC_CAP_LSB      = 1;
   localparam int          OSC_CORE_LSB     = 6;
   localparam int          OSC_TUNE_BIT     = 9;
   localparam int          OSC_ASCALE_BIT   = 16;
   // gain_and_divider_control fields
   localparam int          DIV_LSB          = 0;
   localparam int          GAIN1_LSB        = 6;
   localparam int          GAIN2_LSB        = 8;
   localparam int          DIVGAIN_BIT      = 10;
   localparam logic [5:0]  DIV_MAX          = 6'h3E;
   localparam logic [5:0]  DIV_MUTE_CODE    = 6'h00;
   localparam logic [5:0]  DIV_ONE_CODE     = 6'h01;
   typedef enum logic [1:0] {
      APV_OST_HIZ,
      APV_OST_HOLD,
      APV_OST_HIGH,
      APV_OST_LOW
   } apv_ost_t;
endpackage

// *** apv_aux_if.sv ***
// carrier between the register bank and the auxiliary pin driver
`timescale 1ns/1ps
interface apv_aux_if;
   logic       spi_mode;
   logic [2:0] gpo_val;
   logic [1:0] route;
   logic [1:0] out_state;
   logic [2:0] spi_pins;
   logic       spi_active;
   logic       status_sig;
   logic [2:0] pin_out;
   logic [2:0] pin_oe;
   modport cfg (output spi_mode, gpo_val, route, out_state, spi_pins,
                spi_active, status_sig, input pin_out, pin_oe);
   modport drv (input spi_mode, gpo_val, route, out_state, spi_pins,
                spi_active, status_sig, output pin_out, pin_oe);
endinterface

// *** apv_aux_drv.sv ***
// auxiliary pin driver: serial master, static outputs, status routing
`timescale 1ns/1ps
module apv_aux_drv (
   input  wire logic clk,
   input  wire logic rst_n,
   apv_aux_if.drv    aux
);
   logic [2:0] pin_nxt;
   logic [2:0] oe_nxt;
   logic [2:0] pin_r;
   logic [2:0] oe_r;

   always_comb begin
      pin_nxt = pin_r;
      oe_nxt  = 3'h7;
      if (aux.spi_mode) begin
         if (aux.spi_active) begin
            pin_nxt = aux.spi_pins;
         end else begin
            case (apv_pkg::apv_ost_t'(aux.out_state))
               apv_pkg::APV_OST_HIZ:  oe_nxt  = 3'h0;
               apv_pkg::APV_OST_HOLD: pin_nxt = pin_r;
               apv_pkg::APV_OST_HIGH: pin_nxt = 3'h7;
               apv_pkg::APV_OST_LOW:  pin_nxt = 3'h0;
               default:               oe_nxt  = 3'h0;
            endcase
         end
      end else begin
         pin_nxt = aux.gpo_val;
      end
      if (aux.route != 2'h0) begin
         pin_nxt[aux.route - 2'h1] = aux.status_sig;
         oe_nxt[aux.route - 2'h1]  = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_r <= 3'h0;
         oe_r  <= 3'h0;
      end else begin
         pin_r <= pin_nxt;
         oe_r  <= oe_nxt;
      end
   end

   assign aux.pin_out = pin_r;
   assign aux.pin_oe  = oe_r;
endmodule

// *** apv_top.sv ***
// register bank for auxiliary port, manual oscillator and output divider
//
// Behaviour
// - mode bit 1 runs the three auxiliary pins as a serial master
// - mode bit 0 drives each pin from its static output value bit
// - level select bit picks 1.8 V (0) or 3.3 V (1) drive in static mode; serial mode is always 1.8 V
// - phase sync bit makes chip enable trigger phase sync, exact mode only
// - routing field sends status signal to no pin or pin 0, 1, 2
// - manual calibration bit replaces automatic oscillator calibration
// - core selection picks sub-band; capacitor field, reset 16, sets capacitor
// - manual tune enable bit turns manual oscillator tuning on or off
// - auto-scale bit scales charge pump current from frequency and capacitor
// - divide code 1 is divide by 1, evens to 62, odd rounds down
// - divide code 0 mutes output stages, oscillator and buffer stay on
`timescale 1ns/1ps
module apv_top (
   input  wire logic        CLK,
   input  wire logic        NRST,
   input  wire logic [4:0]  REG_ADDR,
   input  wire logic [23:0] REG_WDATA,
   input  wire logic        REG_WE,
   output logic      [23:0] REG_RDATA,
   input  wire logic        CHIP_EN,
   input  wire logic        EXACT_FREQ_EN,
   input  wire logic        GENERAL_PURPOSE_OUT,
   input  wire logic [2:0]  AUX_SPI_PINS,
   input  wire logic        AUX_SPI_ACTIVE,
   output logic      [2:0]  AUX_PIN_OUT,
   output logic      [2:0]  AUX_PIN_OE,
   output logic             AUX_LEVEL_3V3,
   output logic             PHASE_SYNC_TRIG,
   output logic             MAN_CAL_EN,
   output logic      [4:0]  CAP_SWITCH,
   output logic      [2:0]  OSC_CORE_SEL,
   output logic             MAN_TUNE_EN,
   output logic             CHARGE_PUMP_AUTOSCALE,
   output logic      [5:0]  DIV_RATIO,
   output logic             OUT_MUTE,
   output logic      [1:0]  LO1_GAIN,
   output logic      [1:0]  SECOND_OSC_OUTPUT_GAIN,
   output logic             DIV_STAGE_GAIN
);
   logic        rst_s1_r;
   logic        rst_n_r;
   logic [23:0] aux_ctrl_r;
   logic [23:0] man_osc_r;
   logic [23:0] gain_div_r;
   logic [23:0] rdata_nxt;
   logic        chip_en_d_r;
   logic [5:0]  div_code;
   logic [5:0]  div_nxt;

   apv_aux_if aux ();

   ////////////////////////////////////////////////////////////////////////
   // reset release
   always_ff @(posedge CLK or negedge NRST) begin
      if (!NRST) begin
         rst_s1_r <= 1'b0;
         rst_n_r  <= 1'b0;
      end else begin
         rst_s1_r <= 1'b1;
         rst_n_r  <= rst_s1_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // register writes, reserved bits kept as written
   always_ff @(posedge CLK or negedge rst_n_r) begin
      if (!rst_n_r) begin
         aux_ctrl_r <= apv_pkg::RST_AUX_CTRL;
         man_osc_r  <= apv_pkg::RST_MAN_OSC;
         gain_div_r <= apv_pkg::RST_GAIN_DIV;
      end else if (REG_WE) begin
         case (REG_ADDR)
            apv_pkg::ADDR_AUX_CTRL: aux_ctrl_r <= REG_WDATA;
            apv_pkg::ADDR_MAN_OSC:  man_osc_r  <= REG_WDATA;
            apv_pkg::ADDR_GAIN_DIV: gain_div_r <= REG_WDATA;
            default:                ;
         endcase
      end
   end

   always_comb begin
      case (REG_ADDR)
         apv_pkg::ADDR_AUX_CTRL: rdata_nxt = aux_ctrl_r;
         apv_pkg::ADDR_MAN_OSC:  rdata_nxt = man_osc_r;
         apv_pkg::ADDR_GAIN_DIV: rdata_nxt = gain_div_r;
         default:                rdata_nxt = 24'h000000;
      endcase
   end

   always_ff @(posedge CLK or negedge rst_n_r) begin
      if (!rst_n_r) begin
         REG_RDATA <= 24'h000000;
      end else begin
         REG_RDATA <= rdata_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // auxiliary port
   assign aux.spi_mode   = aux_ctrl_r[apv_pkg::AUX_MODE_BIT];
   assign aux.gpo_val    = aux_ctrl_r[apv_pkg::AUX_VAL_LSB +: 3];
   assign aux.route      = aux_ctrl_r[apv_pkg::AUX_ROUTE_LSB +: 2];
   assign aux.out_state  = aux_ctrl_r[apv_pkg::AUX_OST_LSB +: 2];
   assign aux.spi_pins   = AUX_SPI_PINS;
   assign aux.spi_active = AUX_SPI_ACTIVE;
   assign aux.status_sig = GENERAL_PURPOSE_OUT;

   apv_aux_drv u_aux_drv (
      .clk   (CLK),
      .rst_n (rst_n_r),
      .aux   (aux.drv)
   );

   assign AUX_PIN_OUT = aux.pin_out;
   assign AUX_PIN_OE  = aux.pin_oe;

   ////////////////////////////////////////////////////////////////////////
   // phase sync trigger on chip enable rising edge
   always_ff @(posedge CLK or negedge rst_n_r) begin
      if (!rst_n_r) begin
         // starts high: a chip enable already up at reset is no edge
         chip_en_d_r     <= 1'b1;
         PHASE_SYNC_TRIG <= 1'b0;
      end else begin
         chip_en_d_r     <= CHIP_EN;
         PHASE_SYNC_TRIG <= CHIP_EN & ~chip_en_d_r & EXACT_FREQ_EN
                            & aux_ctrl_r[apv_pkg::AUX_PSYNC_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // output divider decode
   assign div_code = gain_div_r[apv_pkg::DIV_LSB +: 6];

   always_comb begin
      if (div_code == apv_pkg::DIV_MUTE_CODE) begin
         div_nxt = apv_pkg::DIV_MUTE_CODE;
      end else if (div_code == apv_pkg::DIV_ONE_CODE) begin
         div_nxt = apv_pkg::DIV_ONE_CODE;
      end else if (div_code > apv_pkg::DIV_MAX) begin
         div_nxt = apv_pkg::DIV_MAX;
      end else begin
         div_nxt = {div_code[5:1], 1'b0};
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // registered configuration outputs
   always_ff @(posedge CLK or negedge rst_n_r) begin
      if (!rst_n_r) begin
         AUX_LEVEL_3V3          <= 1'b0;
         MAN_CAL_EN             <= 1'b0;
         CAP_SWITCH             <= 5'h00;
         OSC_CORE_SEL           <= 3'h0;
         MAN_TUNE_EN            <= 1'b0;
         CHARGE_PUMP_AUTOSCALE  <= 1'b0;
         DIV_RATIO              <= 6'h00;
         OUT_MUTE               <= 1'b0;
         LO1_GAIN               <= 2'h0;
         SECOND_OSC_OUTPUT_GAIN <= 2'h0;
         DIV_STAGE_GAIN         <= 1'b0;
      end else begin
         AUX_LEVEL_3V3 <= ~aux_ctrl_r[apv_pkg::AUX_MODE_BIT]
                          & aux_ctrl_r[apv_pkg::AUX_LVL_BIT];
         MAN_CAL_EN    <= man_osc_r[apv_pkg::OSC_MCAL_BIT];
         CAP_SWITCH    <= man_osc_r[apv_pkg::OSC_CAP_LSB +: 5];
         OSC_CORE_SEL  <= man_osc_r[apv_pkg::OSC_CORE_LSB +: 3];
         MAN_TUNE_EN   <= man_osc_r[apv_pkg::OSC_TUNE_BIT];
         CHARGE_PUMP_AUTOSCALE <= man_osc_r[apv_pkg::OSC_ASCALE_BIT];
         DIV_RATIO     <= div_nxt;
         OUT_MUTE      <= (div_code == apv_pkg::DIV_MUTE_CODE);
         LO1_GAIN      <= gain_div_r[apv_pkg::GAIN1_LSB +: 2];
         SECOND_OSC_OUTPUT_GAIN <= gain_div_r[apv_pkg::GAIN2_LSB +: 2];
         DIV_STAGE_GAIN <= gain_div_r[apv_pkg::DIVGAIN_BIT];
      end
   end
endmodule

// *** apv_top_checker.sv ***
// port assertions for the register bank
`timescale 1ns/1ps
module apv_top_checker (
   input wire logic        CLK,
   input wire logic        NRST,
   input wire logic [4:0]  REG_ADDR,
   input wire logic [23:0] REG_WDATA,
   input wire logic        REG_WE,
   input wire logic [23:0] REG_RDATA,
   input wire logic        CHIP_EN,
   input wire logic        EXACT_FREQ_EN,
   input wire logic        GENERAL_PURPOSE_OUT,
   input wire logic [2:0]  AUX_PIN_OUT,
   input wire logic [2:0]  AUX_PIN_OE,
   input wire logic        AUX_LEVEL_3V3,
   input wire logic        PHASE_SYNC_TRIG,
   input wire logic [5:0]  DIV_RATIO,
   input wire logic        OUT_MUTE
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!NRST);
   wire w14 = REG_WE && REG_ADDR == 5'h14;
   wire w16 = REG_WE && REG_ADDR == 5'h16;
   wire map = REG_ADDR inside {5'h14, 5'h15, 5'h16};
   property p_psync;
      PHASE_SYNC_TRIG |->
         $past(CHIP_EN) && !$past(CHIP_EN, 2) && $past(EXACT_FREQ_EN);
   endproperty
   property p_mute; OUT_MUTE |-> DIV_RATIO == 6'h00; endproperty
   property p_div;
      DIV_RATIO != 6'h01 |-> !DIV_RATIO[0] && DIV_RATIO <= 6'h3E;
   endproperty
   property p_wr16;
      w16 |=> ##1 OUT_MUTE == ($past(REG_WDATA[5:0], 2) == 6'h00);
   endproperty
   property p_rd;
      map && REG_WE ##1 (!REG_WE && $stable(REG_ADDR))
         |=> REG_RDATA == $past(REG_WDATA, 2);
   endproperty
   property p_static;
      w14 && !REG_WDATA[0] && REG_WDATA[11:10] == 2'h0 |=> ##1
         AUX_PIN_OUT == $past(REG_WDATA[3:1], 2) && AUX_PIN_OE == 3'h7;
   endproperty
   property p_level;
      w14 |=> ##1 AUX_LEVEL_3V3 ==
         ($past(REG_WDATA[4], 2) && !$past(REG_WDATA[0], 2));
   endproperty
   property p_route;
      w14 && REG_WDATA[11:10] != 2'h0 |=> ##1 $past(GENERAL_PURPOSE_OUT)
         == AUX_PIN_OUT[$past(REG_WDATA[11:10], 2) - 1];
   endproperty
   a_psync: assert property (p_psync) else $error("bad sync pulse");
   a_mute: assert property (p_mute) else $error("mute ratio");
   a_div: assert property (p_div) else $error("bad ratio");
   a_wr16: assert property (p_wr16) else $error("mute decode");
   a_rd: assert property (p_rd) else $error("readback");
   a_static: assert property (p_static) else $error("static pins");
   a_level: assert property (p_level) else $error("level");
   a_route: assert property (p_route) else $error("routing");
   c_psync: cover property (PHASE_SYNC_TRIG);
   c_mute: cover property (OUT_MUTE);
   c_serial: cover property (w14 && REG_WDATA[0]);
endmodule
bind apv_top apv_top_checker apv_top_checker_i (.CLK(CLK), .NRST(NRST),
   .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_WE(REG_WE),
   .REG_RDATA(REG_RDATA), .CHIP_EN(CHIP_EN), .EXACT_FREQ_EN(EXACT_FREQ_EN),
   .GENERAL_PURPOSE_OUT(GENERAL_PURPOSE_OUT), .AUX_PIN_OUT(AUX_PIN_OUT),
   .AUX_PIN_OE(AUX_PIN_OE), .AUX_LEVEL_3V3(AUX_LEVEL_3V3),
   .PHASE_SYNC_TRIG(PHASE_SYNC_TRIG), .DIV_RATIO(DIV_RATIO),
   .OUT_MUTE(OUT_MUTE));

// *** apv_top_tb.sv ***
// self-checking testbench for the register bank
`timescale 1ns/1ps
module apv_top_tb;
   logic        CLK, NRST, REG_WE, CHIP_EN, EXACT_FREQ_EN, AUX_LEVEL_3V3;
   logic        GENERAL_PURPOSE_OUT, AUX_SPI_ACTIVE, PHASE_SYNC_TRIG;
   logic        MAN_CAL_EN, MAN_TUNE_EN, OUT_MUTE, CHARGE_PUMP_AUTOSCALE;
   logic        DIV_STAGE_GAIN;
   logic [1:0]  LO1_GAIN, SECOND_OSC_OUTPUT_GAIN;
   logic [2:0]  AUX_SPI_PINS, AUX_PIN_OUT, AUX_PIN_OE, OSC_CORE_SEL;
   logic [4:0]  REG_ADDR, CAP_SWITCH;
   logic [5:0]  DIV_RATIO;
   logic [23:0] REG_WDATA, REG_RDATA;
   int          fail_count, check_count;
   apv_top apv_top_i (.CLK(CLK), .NRST(NRST), .REG_ADDR(REG_ADDR),
      .REG_WDATA(REG_WDATA), .REG_WE(REG_WE), .REG_RDATA(REG_RDATA),
      .CHIP_EN(CHIP_EN), .EXACT_FREQ_EN(EXACT_FREQ_EN),
      .GENERAL_PURPOSE_OUT(GENERAL_PURPOSE_OUT), .AUX_SPI_PINS(AUX_SPI_PINS),
      .AUX_SPI_ACTIVE(AUX_SPI_ACTIVE), .AUX_PIN_OUT(AUX_PIN_OUT),
      .AUX_PIN_OE(AUX_PIN_OE), .AUX_LEVEL_3V3(AUX_LEVEL_3V3),
      .PHASE_SYNC_TRIG(PHASE_SYNC_TRIG), .MAN_CAL_EN(MAN_CAL_EN),
      .CAP_SWITCH(CAP_SWITCH), .OSC_CORE_SEL(OSC_CORE_SEL),
      .MAN_TUNE_EN(MAN_TUNE_EN), .DIV_RATIO(DIV_RATIO), .OUT_MUTE(OUT_MUTE),
      .CHARGE_PUMP_AUTOSCALE(CHARGE_PUMP_AUTOSCALE), .LO1_GAIN(LO1_GAIN),
      .SECOND_OSC_OUTPUT_GAIN(SECOND_OSC_OUTPUT_GAIN),
      .DIV_STAGE_GAIN(DIV_STAGE_GAIN));
   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // write leaves the address up so the readback shows at return
   task automatic wr(input logic [4:0] a, input logic [23:0] d);
      @(negedge CLK);
      {REG_WE, REG_ADDR, REG_WDATA} = {1'b1, a, d};
      @(negedge CLK);
      REG_WE = 1'b0;
      @(negedge CLK);
   endtask
   task automatic rd(input logic [4:0] a, input logic [23:0] exp);
      @(negedge CLK);
      REG_ADDR = a;
      @(negedge CLK);
      chk(REG_RDATA, exp);
   endtask
   task automatic t_reset;
      rd(5'h14, 24'h000220);
      rd(5'h15, 24'h0F48A0);
      rd(5'h16, 24'h0006C1);
      chk({MAN_CAL_EN, CAP_SWITCH, OSC_CORE_SEL, MAN_TUNE_EN,
           CHARGE_PUMP_AUTOSCALE}, 11'h209);
      chk({DIV_RATIO, LO1_GAIN, SECOND_OSC_OUTPUT_GAIN, DIV_STAGE_GAIN},
          11'h03D);
   endtask
   task automatic t_osc;
      wr(5'h15, 24'h0003FF);
      chk({MAN_CAL_EN, CAP_SWITCH, OSC_CORE_SEL, MAN_TUNE_EN,
           CHARGE_PUMP_AUTOSCALE}, 11'h7FE);
      wr(5'h15, 24'h010000);
      chk({MAN_CAL_EN, CAP_SWITCH, OSC_CORE_SEL, MAN_TUNE_EN,
           CHARGE_PUMP_AUTOSCALE}, 11'h001);
   endtask
   task automatic t_div;
      logic [5:0] c [7] = '{6'h00, 6'h01, 6'h03, 6'h06, 6'h3D, 6'h3E, 6'h3F};
      logic [5:0] e [7] = '{6'h00, 6'h01, 6'h02, 6'h06, 6'h3C, 6'h3E, 6'h3E};
      for (int i = 0; i < 7; i++) begin
         wr(5'h16, 24'hFFF800 | c[i]);
         chk(DIV_RATIO, e[i]);
         chk(OUT_MUTE, c[i] == 6'h00);
      end
      wr(5'h17, 24'h000000);
      chk(REG_RDATA, 24'h000000);
      rd(5'h16, 24'hFFF83F);
   endtask
   task automatic t_static;
      for (int v = 0; v < 8; v++) begin
         wr(5'h14, {19'h0, v[0], v[2:0], 1'b0});
         chk({AUX_PIN_OUT, AUX_PIN_OE}, {v[2:0], 3'h7});
         chk(AUX_LEVEL_3V3, v[0]);
      end
   endtask
   task automatic t_serial;
      {AUX_SPI_PINS, AUX_SPI_ACTIVE} = {3'h5, 1'b1};
      wr(5'h14, 24'h001011);
      chk({AUX_PIN_OUT, AUX_PIN_OE, AUX_LEVEL_3V3}, 7'h5E);
      {AUX_SPI_PINS, AUX_SPI_ACTIVE} = {3'h2, 1'b0};
      repeat (2) @(negedge CLK);
      chk(AUX_PIN_OUT, 3'h5);
      for (int s = 2; s < 5; s++) begin
         wr(5'h14, {10'h0, s[1:0], 11'h0, 1'b1});
         chk(AUX_PIN_OUT & AUX_PIN_OE, s == 2 ? 3'h7 : 3'h0);
         chk(AUX_PIN_OE, s == 4 ? 3'h0 : 3'h7);
      end
   endtask
   task automatic t_route;
      GENERAL_PURPOSE_OUT = 1'b1;
      for (int k = 1; k < 4; k++) begin
         wr(5'h14, {12'h0, k[1:0], 10'h0});
         chk(AUX_PIN_OUT, 3'h1 << (k - 1));
      end
      GENERAL_PURPOSE_OUT = 1'b0;
      wr(5'h14, 24'h000C0E);
      chk(AUX_PIN_OUT, 3'h3);
   endtask
   task automatic t_psync(input logic [23:0] cfg, input logic ex, exp);
      wr(5'h14, cfg);
      {EXACT_FREQ_EN, CHIP_EN} = {ex, 1'b1};
      @(negedge CLK);
      chk(PHASE_SYNC_TRIG, exp);
      @(negedge CLK);
      chk(PHASE_SYNC_TRIG, 1'b0);
      CHIP_EN = 1'b0;
      @(negedge CLK);
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      CLK = 1'b0;
      forever #5 CLK = ~CLK;
   end
   initial begin
      #200000;
      fail_count++;
      report_and_stop;
   end
   initial begin
      {NRST, REG_WE, CHIP_EN, EXACT_FREQ_EN, GENERAL_PURPOSE_OUT} = '0;
      {AUX_SPI_ACTIVE, AUX_SPI_PINS, REG_ADDR, REG_WDATA} = '0;
      repeat (20) @(negedge CLK);
      NRST = 1'b1;
      repeat (3) @(negedge CLK);
      t_reset;
      t_osc;
      t_div;
      t_static;
      t_serial;
      t_route;
      t_psync(24'h000200, 1'b1, 1'b1);
      t_psync(24'h000200, 1'b0, 1'b0);
      t_psync(24'h000000, 1'b1, 1'b0);
      report_and_stop;
   end
endmodule
